/* common/dtm_pkg.sv */
package dtm_pkg;

    // register offsets (byte addresses on the 8-bit register port)
    localparam logic [7:0] CPU_IFACE_OPERATING_POINT_ADDR = 8'h8A;
    localparam logic [7:0] REMOTE1_OPERATING_POINT_ADDR = 8'h8B;
    localparam logic [7:0] LOCAL_OPERATING_POINT_ADDR = 8'h8C;
    localparam logic [7:0] REMOTE2_OPERATING_POINT_ADDR = 8'h8D;
    localparam logic [7:0] DYNAMIC_FLOOR_CONTROL_ONE_ADDR = 8'h8E;

    // power-on values
    localparam logic [7:0] CPU_IFACE_OPERATING_POINT_RST = 8'hFB;
    localparam logic [7:0] CHANNEL_OPERATING_POINT_RST = 8'h64;
    localparam logic [7:0] DYNAMIC_FLOOR_CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] TMIN_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // fields of dynamic_floor_control_one
    localparam int REMOTE2_CYCLE_CODE_MSB_BIT = 0;
    localparam int CORE_VOLT_LOW_OPTION_BIT = 1;
    localparam int CAPTURE_ENABLE_BASE_BIT = 2;
    localparam int DYNAMIC_ENABLE_BASE_BIT = 5;

    // channel order used by every per-channel vector
    localparam int CHANNELS = 3;
    localparam int CH_REMOTE1 = 0;
    localparam int CH_LOCAL = 1;
    localparam int CH_REMOTE2 = 2;

    // adjustment spacing in monitoring cycles for cycle code 000
    localparam logic [11:0] DECREASE_BASE_CYCLES = 12'h008;
    localparam logic [11:0] INCREASE_BASE_CYCLES = 12'h010;

    // monitoring cycle period and its length in i_mclk cycles
    localparam int CLK_PERIOD_NS = 20;
    localparam int MONITOR_CYCLE_MS = 125;
    localparam int MONITOR_CYCLE_CLKS = (MONITOR_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        PROT_NORMAL = 1'b0,
        PROT_CORE_LOW = 1'b1
    } dtm_prot_type;

endpackage

/* hw/dtm_dynamic_floor.sv */
// The strobed register port was decided locally.
`timescale 1ns/1ps

module dtm_dynamic_floor
    import dtm_pkg::*;
#(
    parameter int MON_CYCLE_CLKS = MONITOR_CYCLE_CLKS
)
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_lock,
    input wire logic i_thermal_limit_input_n,
    input wire logic [2:0][7:0] i_temp,
    input wire logic [2:0][7:0] i_prog_tmin,
    input wire logic [2:0][7:0] i_zone_low,
    input wire logic [2:0][7:0] i_zone_high,
    input wire logic [2:0] i_remote1_cycle_code,
    input wire logic [2:0] i_local_cycle_code,
    input wire logic [1:0] i_remote2_cycle_code_low,
    input wire logic i_standby_supply,
    input wire logic [7:0] i_core_voltage,
    input wire logic [7:0] i_core_voltage_low_limit,
    input wire logic i_alert_enable,
    output logic [2:0][7:0] o_tmin,
    output logic [2:0] o_dynamic_active,
    output logic o_core_low_active,
    output logic o_status1_core_low_set,
    output logic o_alert,
    output logic o_processor_hot_monitor_enable,
    output logic o_shutdown_block
);

    if (MON_CYCLE_CLKS < 2 || MON_CYCLE_CLKS > 16777215)
    begin : g_bad_param
        $error("MON_CYCLE_CLKS must lie between 2 and 2**24-1");
    end

    // monitoring cycles between adjustments for a cycle code
    function automatic logic [11:0] dtm_spacing(input logic [2:0] code, input logic up);
        dtm_spacing = up ? (INCREASE_BASE_CYCLES << code) : (DECREASE_BASE_CYCLES << code);
    endfunction

    // thermal-limit pin: two flops, then edge detect on the second
    logic thermal_limit_input_meta;
    logic thermal_limit_input_sync;
    logic thermal_limit_input_prev;
    logic thermal_limit_input_assert;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            thermal_limit_input_meta <= 1'b1;
            thermal_limit_input_sync <= 1'b1;
            thermal_limit_input_prev <= 1'b1;
        end
        else
        begin
            thermal_limit_input_meta <= i_thermal_limit_input_n;
            thermal_limit_input_sync <= thermal_limit_input_meta;
            thermal_limit_input_prev <= thermal_limit_input_sync;
        end
    end

    // pin is active low: assertion is the falling edge
    assign thermal_limit_input_assert = thermal_limit_input_prev & ~thermal_limit_input_sync;

    // monitoring-cycle enable pulse
    logic [23:0] mon_cnt;
    logic [23:0] next_mon_cnt;
    logic mon_tick;
    logic next_mon_tick;

    always_comb
    begin
        next_mon_tick = 1'b0;
        next_mon_cnt = mon_cnt + 24'h000001;
        if (mon_cnt == 24'(MON_CYCLE_CLKS - 1))
        begin
            next_mon_cnt = 24'h000000;
            next_mon_tick = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mon_cnt <= 24'h000000;
            mon_tick <= 1'b0;
        end
        else
        begin
            mon_cnt <= next_mon_cnt;
            mon_tick <= next_mon_tick;
        end
    end

    // register file
    logic [3:0][7:0] op_point;
    logic [3:0][7:0] next_op_point;
    logic [7:0] dyn_ctrl;
    logic [7:0] next_dyn_ctrl;
    logic [7:0] next_rdata;
    logic wr_ok;

    assign wr_ok = i_wr & ~i_lock;

    always_comb
    begin
        next_op_point = op_point;
        next_dyn_ctrl = dyn_ctrl;
        if (wr_ok)
        begin
            case (i_addr)
                CPU_IFACE_OPERATING_POINT_ADDR: next_op_point[0] = i_wdata;
                REMOTE1_OPERATING_POINT_ADDR: next_op_point[1] = i_wdata;
                LOCAL_OPERATING_POINT_ADDR: next_op_point[2] = i_wdata;
                REMOTE2_OPERATING_POINT_ADDR: next_op_point[3] = i_wdata;
                DYNAMIC_FLOOR_CONTROL_ONE_ADDR: next_dyn_ctrl = i_wdata;
                default: next_dyn_ctrl = dyn_ctrl;
            endcase
        end
        // capture is applied after the write so a same-cycle assertion wins
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (thermal_limit_input_assert && dyn_ctrl[CAPTURE_ENABLE_BASE_BIT + c])
            begin
                next_op_point[c + 1] = i_temp[c];
            end
        end
    end

    always_comb
    begin
        case (i_addr)
            CPU_IFACE_OPERATING_POINT_ADDR: next_rdata = op_point[0];
            REMOTE1_OPERATING_POINT_ADDR: next_rdata = op_point[1];
            LOCAL_OPERATING_POINT_ADDR: next_rdata = op_point[2];
            REMOTE2_OPERATING_POINT_ADDR: next_rdata = op_point[3];
            DYNAMIC_FLOOR_CONTROL_ONE_ADDR: next_rdata = dyn_ctrl;
            default: next_rdata = UNMAPPED_READ_VALUE;
        endcase
        if (!i_rd)
        begin
            next_rdata = UNMAPPED_READ_VALUE;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            op_point[0] <= CPU_IFACE_OPERATING_POINT_RST;
            op_point[1] <= CHANNEL_OPERATING_POINT_RST;
            op_point[2] <= CHANNEL_OPERATING_POINT_RST;
            op_point[3] <= CHANNEL_OPERATING_POINT_RST;
            dyn_ctrl <= DYNAMIC_FLOOR_CONTROL_ONE_RST;
            o_rdata <= UNMAPPED_READ_VALUE;
        end
        else
        begin
            op_point <= next_op_point;
            dyn_ctrl <= next_dyn_ctrl;
            o_rdata <= next_rdata;
        end
    end

    // core-voltage-low protection
    dtm_prot_type prot_state;
    dtm_prot_type next_prot_state;
    logic core_low_cond;
    logic core_high_cond;
    logic next_status_set;

    assign core_low_cond = dyn_ctrl[CORE_VOLT_LOW_OPTION_BIT] & i_standby_supply
        & (i_core_voltage < i_core_voltage_low_limit);
    assign core_high_cond = i_core_voltage > i_core_voltage_low_limit;

    always_comb
    begin
        next_prot_state = prot_state;
        next_status_set = 1'b0;
        case (prot_state)
            PROT_NORMAL:
            begin
                if (core_low_cond)
                begin
                    next_prot_state = PROT_CORE_LOW;
                    next_status_set = 1'b1;
                end
            end
            PROT_CORE_LOW:
            begin
                // equal to the limit holds protection; only a rise above ends it
                if (core_high_cond)
                begin
                    next_prot_state = PROT_NORMAL;
                end
            end
            default: next_prot_state = PROT_NORMAL;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prot_state <= PROT_NORMAL;
            o_status1_core_low_set <= 1'b0;
            o_core_low_active <= 1'b0;
            o_alert <= 1'b0;
            o_processor_hot_monitor_enable <= 1'b1;
            o_shutdown_block <= 1'b0;
        end
        else
        begin
            prot_state <= next_prot_state;
            o_status1_core_low_set <= next_status_set;
            o_core_low_active <= next_prot_state == PROT_CORE_LOW;
            o_alert <= (next_prot_state == PROT_CORE_LOW) & i_alert_enable;
            o_processor_hot_monitor_enable <= next_prot_state == PROT_NORMAL;
            o_shutdown_block <= next_prot_state == PROT_CORE_LOW;
        end
    end

    // per-channel floor adjustment
    logic [2:0][2:0] cycle_code;

    assign cycle_code[CH_REMOTE1] = i_remote1_cycle_code;
    assign cycle_code[CH_LOCAL] = i_local_cycle_code;
    assign cycle_code[CH_REMOTE2] =
        {dyn_ctrl[REMOTE2_CYCLE_CODE_MSB_BIT], i_remote2_cycle_code_low};

    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_chan
        logic [11:0] wait_cnt;
        logic [11:0] next_wait_cnt;
        logic [7:0] next_tmin;
        logic enabled;
        logic active;
        logic [7:0] temp;
        logic [7:0] point;

        assign temp = i_temp[c];
        assign point = op_point[c + 1];
        assign enabled = dyn_ctrl[DYNAMIC_ENABLE_BASE_BIT + c];
        assign active = enabled & (prot_state == PROT_NORMAL);

        always_comb
        begin
            next_tmin = o_tmin[c];
            next_wait_cnt = wait_cnt;
            if (!enabled)
            begin
                // plain automatic control runs on the programmed floor
                next_tmin = i_prog_tmin[c];
                next_wait_cnt = 12'h000;
            end
            else if (active && mon_tick)
            begin
                if (wait_cnt != 12'hFFF)
                begin
                    next_wait_cnt = wait_cnt + 12'h001;
                end
                // too hot: lower the floor so fans start earlier
                if ((temp > point || temp >= i_zone_high[c]) && o_tmin[c] != 8'h00
                    && wait_cnt >= dtm_spacing(cycle_code[c], 1'b0) - 12'h001)
                begin
                    next_tmin = o_tmin[c] - 8'h01;
                    next_wait_cnt = 12'h000;
                end
                // well below the zone: raise the floor, never above the point
                else if (temp < i_zone_low[c] && o_tmin[c] < point
                    && wait_cnt >= dtm_spacing(cycle_code[c], 1'b1) - 12'h001)
                begin
                    next_tmin = o_tmin[c] + 8'h01;
                    next_wait_cnt = 12'h000;
                end
            end
            // while protected an enabled channel's floor and count freeze
        end

        always_ff @(posedge i_mclk or posedge i_rst)
        begin
            if (i_rst)
            begin
                o_tmin[c] <= TMIN_RST;
                wait_cnt <= 12'h000;
                o_dynamic_active[c] <= 1'b0;
            end
            else
            begin
                o_tmin[c] <= next_tmin;
                wait_cnt <= next_wait_cnt;
                o_dynamic_active[c] <= enabled & (next_prot_state == PROT_NORMAL);
            end
        end
    end

endmodule // dtm_dynamic_floor

/* bench/dtm_dynamic_floor_asserts.sv */
`timescale 1ns/1ps

module dtm_dynamic_floor_asserts
    import dtm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_lock,
    input wire logic i_standby_supply,
    input wire logic [7:0] i_core_voltage,
    input wire logic [7:0] i_core_voltage_low_limit,
    input wire logic [2:0] o_dynamic_active,
    input wire logic o_core_low_active,
    input wire logic o_status1_core_low_set,
    input wire logic o_alert,
    input wire logic o_processor_hot_monitor_enable,
    input wire logic o_shutdown_block
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_map_rd;
        i_rd && !i_wr && i_addr >= 8'h8A && i_addr <= 8'h8E;
    endsequence
    sequence s_wr_open;
        i_wr && !i_lock && i_addr >= 8'h8A && i_addr <= 8'h8E;
    endsequence
    sequence s_wr_locked;
        i_wr && i_lock && i_addr == $past(i_addr);
    endsequence
    sequence s_rd_same;
        i_rd && !i_wr && i_addr == $past(i_addr);
    endsequence

    a_read_back: assert property (s_wr_open ##1 s_rd_same |=> o_rdata == $past(i_wdata, 2))
        else $error("read after write mismatch");
    a_lock_drop: assert property (s_map_rd ##1 s_wr_locked ##1 s_rd_same |=>
        o_rdata == $past(o_rdata, 2))
        else $error("locked write changed a register");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_prot_cause: assert property ($rose(o_core_low_active) |-> $past(i_standby_supply) &&
        $past(i_core_voltage) < $past(i_core_voltage_low_limit))
        else $error("protection entered without cause");
    a_prot_hold: assert property (o_core_low_active &&
        i_core_voltage <= i_core_voltage_low_limit |=> o_core_low_active)
        else $error("protection left too early");
    a_status_pulse: assert property (o_status1_core_low_set |->
        o_core_low_active && !$past(o_core_low_active))
        else $error("status pulse not at entry");
    a_alert_gate: assert property (o_alert |-> o_core_low_active)
        else $error("alert outside protection");
    a_prot_outputs: assert property (o_core_low_active |-> !o_processor_hot_monitor_enable &&
        o_shutdown_block && o_dynamic_active == 3'h0)
        else $error("function not suspended");
    a_prot_exit: assert property (o_core_low_active &&
        i_core_voltage > i_core_voltage_low_limit |=> !o_core_low_active)
        else $error("protection not left");
    a_normal_outs: assert property (!o_core_low_active |->
        o_processor_hot_monitor_enable && !o_shutdown_block && !o_alert)
        else $error("function not restored");
endmodule // dtm_dynamic_floor_asserts

bind dtm_dynamic_floor dtm_dynamic_floor_asserts u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_lock(i_lock), .i_standby_supply(i_standby_supply), .i_core_voltage(i_core_voltage),
    .i_core_voltage_low_limit(i_core_voltage_low_limit), .o_dynamic_active(o_dynamic_active),
    .o_core_low_active(o_core_low_active), .o_status1_core_low_set(o_status1_core_low_set),
    .o_alert(o_alert), .o_processor_hot_monitor_enable(o_processor_hot_monitor_enable),
    .o_shutdown_block(o_shutdown_block));

/* bench/dynamic_tmin_operating_point_tb.sv */
`timescale 1ns/1ps

module dynamic_tmin_operating_point_tb;
    import dtm_pkg::*;
    localparam int MON = 4;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_lock = 1'b0, pin_n = 1'b1;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, cv = 8'h90, cv_lim = 8'h80;
    logic [2:0][7:0] temp = '0, prog = '0, zlo = '0, zhi = '1, tmin;
    logic stby = 1'b0, alert_en = 1'b0, rd_seen = 1'b0;
    logic [1:0] c2lo = 2'h0;
    logic [2:0] dyn;
    logic [7:0] rdata, v [5], tc;
    logic prot, stat, alert, hot_en, shut;
    logic [7:0] exp_q [$];
    int errors = 0, total_checks = 0, seed, n;

    dtm_dynamic_floor #(.MON_CYCLE_CLKS(MON)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_lock(i_lock), .i_thermal_limit_input_n(pin_n), .i_temp(temp), .i_prog_tmin(prog),
        .i_zone_low(zlo), .i_zone_high(zhi), .i_remote1_cycle_code(3'h0),
        .i_local_cycle_code(3'h0), .i_remote2_cycle_code_low(c2lo), .i_standby_supply(stby),
        .i_core_voltage(cv), .i_core_voltage_low_limit(cv_lim), .i_alert_enable(alert_en),
        .o_tmin(tmin), .o_dynamic_active(dyn), .o_core_low_active(prot),
        .o_status1_core_low_set(stat), .o_alert(alert),
        .o_processor_hot_monitor_enable(hot_en), .o_shutdown_block(shut));

    always #10 i_mclk = ~i_mclk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // strobes stay as set until the next transfer or idle, so back to back calls never
    // assign a strobe twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_addr <= a;
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_mclk);
    endtask

    task automatic idle;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic pulse_pin;
        idle();
        pin_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        pin_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
    endtask

    // clocks between two successive floor steps of remote 2, then the size of the second step
    task automatic gap(input logic [2:0] code, input logic up, input int ticks);
        int k;
        c2lo <= code[1:0];
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h80 | {7'h00, code[2]});
        idle();
        k = 0;
        n = 0;
        @(negedge i_mclk);
        tc = tmin[2];
        while (tmin[2] === tc && k < 9000)
        begin
            @(negedge i_mclk);
            k++;
        end
        tc = tmin[2];
        while (tmin[2] === tc && k < 9000)
        begin
            @(negedge i_mclk);
            k++;
            n++;
        end
        if (k >= 9000)
        begin
            errors++;
            tally_and_finish();
        end
        check({7'h00, n == ticks * MON}, 8'h01);
        check(tmin[2], up ? tc + 8'h01 : tc - 8'h01);
        @(posedge i_mclk);
    endtask

    always @(posedge i_mclk) rd_seen <= i_rd;
    always @(negedge i_mclk)
    begin
        if (rd_seen === 1'b1 && exp_q.size() > 0)
            check(rdata, exp_q.pop_front());
    end

    initial
    begin
        seed = 32'h420b3cbf;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        rd(CPU_IFACE_OPERATING_POINT_ADDR, 8'hFB);
        for (int a = 0; a < 3; a++)
            rd(REMOTE1_OPERATING_POINT_ADDR + a[7:0], 8'h64);
        rd(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h00);
        wr(8'h8F, 8'hFF);
        rd(8'h8F, UNMAPPED_READ_VALUE);
        rd(8'h89, UNMAPPED_READ_VALUE);
        $display("reset values done");
        // random data may set the capture and option bits; later tests rewrite the control register before using them
        for (int a = 0; a < 5; a++)
        begin
            v[a] = 8'($random(seed));
            wr(8'h8A + a[7:0], v[a]);
            rd(8'h8A + a[7:0], v[a]);
            i_lock <= 1'b1;
            wr(8'h8A + a[7:0], ~v[a]);
            rd(8'h8A + a[7:0], v[a]);
            i_lock <= 1'b0;
        end
        $display("access and lock done");
        prog <= 24'($random(seed));
        temp <= '0;
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h20);
        idle();
        // outputs are looked at on the falling edge, where they have settled
        @(negedge i_mclk);
        check({5'h00, dyn}, 8'h01);
        check(tmin[1], prog[1]);
        @(posedge i_mclk);
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'hE0);
        idle();
        @(negedge i_mclk);
        check({5'h00, dyn}, 8'h07);
        @(posedge i_mclk);
        $display("enables done");
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h0C);
        temp <= 24'($random(seed));
        pulse_pin();
        rd(REMOTE1_OPERATING_POINT_ADDR, temp[0]);
        rd(LOCAL_OPERATING_POINT_ADDR, temp[1]);
        rd(REMOTE2_OPERATING_POINT_ADDR, v[3]);
        tc = temp[1];
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h14);
        temp <= 24'($random(seed));
        pulse_pin();
        rd(REMOTE2_OPERATING_POINT_ADDR, temp[2]);
        rd(REMOTE1_OPERATING_POINT_ADDR, temp[0]);
        rd(LOCAL_OPERATING_POINT_ADDR, tc);
        $display("capture done");
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h00);
        stby <= 1'b1;
        alert_en <= 1'b1;
        cv <= 8'h70;
        idle();
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        check({7'h00, prot}, 8'h00);
        @(posedge i_mclk);
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'hE2);
        idle();
        @(negedge i_mclk);
        check({prot, alert, hot_en, shut, stat, dyn}, 8'hD8);
        @(negedge i_mclk);
        check({7'h00, stat}, 8'h00);
        @(posedge i_mclk);
        cv <= 8'h80;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        check({7'h00, prot}, 8'h01);
        @(posedge i_mclk);
        cv <= 8'h81;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        check({prot, alert, hot_en, shut, stat, dyn}, 8'h27);
        @(posedge i_mclk);
        stby <= 1'b0;
        $display("protection done");
        temp[2] <= 8'h70;
        prog[2] <= 8'h50;
        wr(REMOTE2_OPERATING_POINT_ADDR, 8'h64);
        // disabling first reloads the floor from the programmed value
        wr(DYNAMIC_FLOOR_CONTROL_ONE_ADDR, 8'h00);
        gap(3'h0, 1'b0, 8);
        gap(3'h5, 1'b0, 256);
        zlo[2] <= 8'h60;
        temp[2] <= 8'h50;
        gap(3'h0, 1'b1, 16);
        $display("floor steps done");
        repeat (2) @(posedge i_mclk);
        tally_and_finish();
    end
endmodule // dynamic_tmin_operating_point_tb
